/* File: core/ssp_pkg.sv */
// Purpose: Shared constants for the serial shift port block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indices are the printed offsets; byte address is 4x

package ssp_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_CTRL = 8'he2; // Transfer control
  localparam logic [7:0] IDX_DIV  = 8'he1; // Divider, length, done flag
  localparam logic [7:0] IDX_DATA = 8'he0; // Data and shift register
  localparam logic [7:0] IDX_AUX  = 8'hdd; // Aux output select, write only

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic       AUX_RST  = 1'b0;

  // ----------------------------------------------------------------------
  // Transfer control fields
  // ----------------------------------------------------------------------
  localparam int unsigned B_ACTIVE = 7;
  localparam int unsigned B_IE     = 6;
  localparam int unsigned B_PHASE  = 5;
  localparam int unsigned B_SRC    = 4;
  localparam int unsigned B_INGATE = 3;
  localparam int unsigned B_GSTART = 2;
  localparam int unsigned B_FBYP   = 1;
  localparam int unsigned B_POL    = 0;

  // ----------------------------------------------------------------------
  // Divider register fields and aux select bit
  // ----------------------------------------------------------------------
  localparam int unsigned B_DONE   = 7;
  localparam int unsigned LEN_HI   = 6;
  localparam int unsigned LEN_LO   = 3;
  localparam int unsigned CD_HI    = 2;
  localparam int unsigned CD_LO    = 0;
  localparam int unsigned B_AUXSEL = 0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam logic [3:0] BASE_DIV_M1 = 4'd12; // Core cycle clock is clk/13

  // Transfer sequencer states
  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_WAIT,
    SSP_SHIFT
  } ssp_state_t;

endpackage : ssp_pkg

/* File: core/ssp_filter.sv */
// Purpose: Noise filter for one serial pin
// Assumes: Input already synchronous to clk
// Notes:   A level must be seen on two edges in a row to pass

`timescale 1ns/100ps

module ssp_filter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Pin and control
  input  wire logic raw,
  input  wire logic bypass,
  output wire logic filt
);

  logic seen_r;
  logic held_r;

  // Two-sample agreement drops one-cycle pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen_r <= 1'b0;
      held_r <= 1'b0;
    end else begin
      seen_r <= raw;
      if (raw == seen_r) begin
        held_r <= raw;
      end
    end
  end

  assign filt = bypass ? raw : held_r;

endmodule : ssp_filter

/* File: core/ssp_port.sv */
// Purpose: Serial shift port with mode control, APB register access
// Assumes: clk is the core clock; pins are synchronous to clk
// Notes:   SCK and serial output use separate out and enable signals
//
// Notes on behaviour
// [R01] One 8-bit shift register sends and receives at the same time.
// [R02] Source bit low: slave on SCK; high: master driving SCK from clk/13.
// [R03] Aux select bit set routes shift output to pin, else plain port line.
// [R04] Done request ORed with port interrupt; done flag tells them apart.
// [R05] Reset clears transfer control; otherwise software reads and writes it.
// [R06] Software never sets gated start and input gating together.
// [R07] Active bit clears itself at end; interrupt if enabled; pollable.
// [R08] Clearing active aborts the transfer and requests an interrupt if enabled.
// [R09] Transfer interrupt enabled only while enable bit six is one.
// [R10] Phase clear: first bit out on load; set: on first change edge.
// [R11] Input gating clear shifts in zeros, set shifts in pin level.
// [R12] Gated start waits for active bit and high serial input level.
// [R13] A started gated transfer runs on if serial input falls.
// [R14] Filter bit zero removes short pulses on input and clock.
// [R15] Polarity picks capture and change edges together with phase.
// [R16] End after programmed bit count; longer frames drop leading bits.
// [R17] Software sets input pin as input; slave clock comes from master.
// [R18] Frame length is a four-bit field, codes one to fifteen.
// [R19] Master divides base clock by 1,2,4,8,16,32,64 or 256.
// [R20] Data shift most significant bit first.
// [R21] Done flag sticky until cleared; divider and data locked while active.
// [R22] Software sets up data and mode before setting active.

`timescale 1ns/100ps

module ssp_port (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ssp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output wire logic [31:0]               prdata,
  output wire logic                      pready,
  output wire logic                      pslverr,
  // Serial clock pin
  input  wire logic                      sck_in,
  output wire logic                      sck_out,
  output wire logic                      sck_oe,
  // Serial data pins
  input  wire logic                      sin,
  output wire logic                      sout_out,
  output wire logic                      sout_oe,
  // Plain port function of the serial output pin
  input  wire logic                      port_out,
  input  wire logic                      port_oe,
  // Shared interrupt vector
  input  wire logic                      port_irq,
  output wire logic                      irq_vec2
);

  import ssp_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Divider code to terminal count of the base tick counter
  function automatic logic [7:0] div_last(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h00;
    unique case (code)
      3'd0: r = 8'h00;
      3'd1: r = 8'h01;
      3'd2: r = 8'h03;
      3'd3: r = 8'h07;
      3'd4: r = 8'h0f;
      3'd5: r = 8'h1f;
      3'd6: r = 8'h3f;
      3'd7: r = 8'hff;
    endcase
    return r;
  endfunction : div_last

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [6:0]  div_r;
  logic        done_r;
  logic        done_nxt;
  logic [7:0]  sr_r;
  logic [7:0]  sr_nxt;
  logic        aux_r;
  logic [31:0] rdata_r;
  logic        out_r;
  logic        sck_lvl_r;
  logic        sck_prev_r;
  logic [3:0]  base_cnt_r;
  logic [7:0]  div_cnt_r;
  logic [3:0]  bit_cnt_r;
  logic [3:0]  bit_cnt_nxt;
  ssp_state_t  state_r;
  ssp_state_t  state_nxt;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire [7:0] idx      = paddr[ADDR_W-1:2];
  wire       hit_ctrl = (idx == IDX_CTRL);
  wire       hit_div  = (idx == IDX_DIV);
  wire       hit_data = (idx == IDX_DATA);
  wire       hit_aux  = (idx == IDX_AUX);
  wire       mapped   = hit_ctrl | hit_div | hit_data | hit_aux;
  wire       setup    = psel & ~penable;
  wire       wr_ok    = psel & penable & pwrite & mapped;
  wire       busy     = ctrl_r[B_ACTIVE];
  wire       wr_ctrl  = wr_ok & hit_ctrl;
  wire       wr_div   = wr_ok & hit_div & ~busy;    // see [R21]
  wire       wr_data  = wr_ok & hit_data & ~busy;   // see [R21]
  wire       wr_aux   = wr_ok & hit_aux;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rdata_r;

  // ----------------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------------
  wire       ie      = ctrl_r[B_IE];
  wire       phase   = ctrl_r[B_PHASE];
  wire       master  = ctrl_r[B_SRC];
  wire       in_gate = ctrl_r[B_INGATE];
  wire       gstart  = ctrl_r[B_GSTART];
  wire       fbyp    = ctrl_r[B_FBYP];
  wire       pol     = ctrl_r[B_POL];
  wire [3:0] flen    = div_r[LEN_HI:LEN_LO];          // see [R18]
  wire [2:0] cdiv    = div_r[CD_HI:CD_LO];

  // ----------------------------------------------------------------------
  // Pin filters
  // ----------------------------------------------------------------------
  logic sin_f;
  logic sck_f;

  // Short glitches removed unless bypassed
  ssp_filter u_fsin (                                 // see [R14]
    .clk    (clk),
    .sys_rst(sys_rst),
    .raw    (sin),
    .bypass (fbyp),
    .filt   (sin_f)
  );

  ssp_filter u_fsck (                                 // see [R14]
    .clk    (clk),
    .sys_rst(sys_rst),
    .raw    (sck_in),
    .bypass (fbyp),
    .filt   (sck_f)
  );

  // ----------------------------------------------------------------------
  // Clock events
  // ----------------------------------------------------------------------
  wire shifting  = (state_r == SSP_SHIFT);
  wire base_tick = (base_cnt_r == BASE_DIV_M1);
  wire half_tick = shifting & master & base_tick
                   & (div_cnt_r == div_last(cdiv));   // see [R19]
  // Master edges from own clock; slave edges from filtered SCK
  wire m_lead    = half_tick & (sck_lvl_r == pol);    // see [R02]
  wire m_trail   = half_tick & (sck_lvl_r != pol);
  wire s_lead    = shifting & ~master & (sck_prev_r == pol)
                   & (sck_f != pol);
  wire s_trail   = shifting & ~master & (sck_prev_r != pol)
                   & (sck_f == pol);
  wire lead_ev   = m_lead | s_lead;
  wire trail_ev  = m_trail | s_trail;
  // Phase picks which edge captures and which one changes data
  wire sample_ev = phase ? trail_ev : lead_ev;        // see [R15]
  wire change_ev = phase ? lead_ev : trail_ev;        // see [R15]
  wire din       = in_gate & sin_f;                   // see [R11]

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  wire wr_act  = wr_ctrl & pwdata[B_ACTIVE];
  wire abort   = (state_r != SSP_IDLE) & wr_ctrl & ~pwdata[B_ACTIVE];
  wire last    = sample_ev & (bit_cnt_nxt == flen);   // see [R16]
  // Master ends once SCK is back at idle; slave at last capture
  wire finish  = shifting & (master ? (m_trail & (bit_cnt_nxt == flen))
                                    : last);
  wire go_now  = ~gstart | sin_f;                     // see [R12]
  wire end_ev  = finish | abort;

  assign bit_cnt_nxt = bit_cnt_r + {3'b000, sample_ev};

  // Next state of the transfer sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSP_IDLE: begin
        if (busy) begin
          state_nxt = go_now ? SSP_SHIFT : SSP_WAIT;  // see [R12]
        end
      end
      SSP_WAIT: begin
        if (abort) begin
          state_nxt = SSP_IDLE;                       // see [R08]
        end else if (sin_f) begin
          state_nxt = SSP_SHIFT;                      // see [R12]
        end
      end
      SSP_SHIFT: begin
        // Serial input level no longer matters here
        if (end_ev) begin
          state_nxt = SSP_IDLE;                       // see [R13] [R08]
        end
      end
    endcase
  end

  // Control register next value, hardware end clears active
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (finish) begin
      ctrl_nxt[B_ACTIVE] = 1'b0;                      // see [R07]
    end
    if (wr_ctrl) begin
      ctrl_nxt = pwdata[7:0];                         // see [R05]
    end
  end

  // Done flag: set at end if enabled, set beats software clear
  always_comb begin
    done_nxt = done_r;
    if (wr_div & ~pwdata[B_DONE]) begin
      done_nxt = 1'b0;
    end
    if (end_ev & ie) begin
      done_nxt = 1'b1;                                // see [R21] [R07] [R08]
    end
  end

  // Shift register: load, or shift MSB first on capture edge
  always_comb begin
    sr_nxt = sr_r;
    if (wr_data) begin
      sr_nxt = pwdata[7:0];
    end else if (sample_ev) begin
      sr_nxt = {sr_r[6:0], din};                      // see [R01] [R20]
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Software visible registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;                             // see [R05]
      div_r  <= DIV_RST[6:0];
      done_r <= DIV_RST[B_DONE];
      sr_r   <= DATA_RST;
      aux_r  <= AUX_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      done_r <= done_nxt;
      sr_r   <= sr_nxt;
      if (wr_div) begin
        div_r <= pwdata[6:0];
      end
      if (wr_aux) begin
        aux_r <= pwdata[B_AUXSEL];
      end
    end
  end

  // Sequencer state and bit counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r   <= SSP_IDLE;
      bit_cnt_r <= 4'h0;
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= shifting ? bit_cnt_nxt : 4'h0;
    end
  end

  // Base clock and bit clock dividers, restart per transfer
  always_ff @(posedge clk) begin
    if (sys_rst || !shifting) begin
      base_cnt_r <= 4'h0;
      div_cnt_r  <= 8'h00;
    end else begin
      base_cnt_r <= base_tick ? 4'h0 : base_cnt_r + 4'h1;
      if (half_tick) begin
        div_cnt_r <= 8'h00;
      end else if (base_tick) begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end

  // Master SCK level, idle at polarity between transfers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_lvl_r <= 1'b0;
    end else if (!shifting) begin
      sck_lvl_r <= pol;                               // see [R15]
    end else if (half_tick) begin
      sck_lvl_r <= ~sck_lvl_r;                        // see [R02]
    end
  end

  // Slave edge history and serial output bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_prev_r <= 1'b0;
      out_r      <= 1'b0;
    end else begin
      sck_prev_r <= shifting ? sck_f : pol;
      if (!shifting && !phase) begin
        out_r <= sr_nxt[7];                           // see [R10]
      end else if (change_ev) begin
        out_r <= sr_r[7];                             // see [R10] [R20]
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (setup) begin
      rdata_r <= 32'h0000_0000;
      if (!pwrite && hit_ctrl) begin
        rdata_r[7:0] <= ctrl_r;
      end else if (!pwrite && hit_div) begin
        rdata_r[7:0] <= {done_r, div_r};
      end else if (!pwrite && hit_data) begin
        rdata_r[7:0] <= sr_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pins and interrupt
  // ----------------------------------------------------------------------
  assign sck_oe   = master;                           // see [R02]
  assign sck_out  = master ? sck_lvl_r : 1'b0;
  assign sout_out = aux_r ? out_r : port_out;         // see [R03]
  assign sout_oe  = aux_r ? 1'b1 : port_oe;           // see [R03]
  assign irq_vec2 = (done_r & ie) | port_irq;         // see [R04] [R09]

endmodule : ssp_port

/* File: dv/ssp_port_sva.sv */
// Purpose: Assertions on the serial shift port pins and APB
// Assumes: Only top ports seen; mode bits mirrored from APB writes
// Notes:   Busy mirror relies on software polling the active bit

`timescale 1ns/100ps

module ssp_port_sva (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        sys_rst,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ssp_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Pins
  input wire logic                        sck_in,
  input wire logic                        sck_out,
  input wire logic                        sck_oe,
  input wire logic                        sin,
  input wire logic                        sout_out,
  input wire logic                        sout_oe,
  input wire logic                        port_out,
  input wire logic                        port_oe,
  input wire logic                        port_irq,
  input wire logic                        irq_vec2
);
  import ssp_pkg::*;

  logic        src_r, ie_r, aux_r, seen_r, busy_r, sck_q;
  logic [2:0]  cd_r;
  logic [11:0] cnt_r;

  // Decoded accesses and expected half period
  wire [7:0]  idx    = paddr[9:2];
  wire        acc    = psel && penable && pready;
  wire        map_ok = idx inside {IDX_CTRL, IDX_DIV, IDX_DATA, IDX_AUX};
  wire        wr_ctl = acc && pwrite && (idx == IDX_CTRL);
  wire        rd_ctl = acc && !pwrite && (idx == IDX_CTRL);
  wire        wr_div = acc && pwrite && (idx == IDX_DIV);
  wire        wr_aux = acc && pwrite && (idx == IDX_AUX);
  wire        tog    = sck_out != sck_q;
  wire [11:0] half   = (cd_r == 3'h7) ? 12'hd00 : (12'h00d << cd_r);

  // Mirror of mode bits and clock edge spacing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {src_r, ie_r, aux_r, seen_r, busy_r, sck_q} <= '0;
      cd_r <= '0;
      cnt_r <= '0;
    end else begin
      sck_q <= sck_out;
      cnt_r <= tog ? 12'h000 : cnt_r + 12'h001;
      if (tog) seen_r <= 1'b1;
      if (!sck_oe || wr_ctl) seen_r <= 1'b0;
      if (wr_ctl) src_r <= pwdata[B_SRC];
      if (wr_ctl) ie_r <= pwdata[B_IE];
      if (wr_ctl) busy_r <= pwdata[B_ACTIVE];
      if (rd_ctl && !prdata[B_ACTIVE]) busy_r <= 1'b0;
      if (wr_div && !busy_r) cd_r <= pwdata[CD_HI:CD_LO];
      if (wr_aux) aux_r <= pwdata[B_AUXSEL];
    end
  end

  AST_SCK_OE: assert property (@(posedge clk)
    disable iff (sys_rst) sck_oe == src_r)
    else $error("sck drive does not follow mode");
  AST_SLAVE_SCK: assert property (@(posedge clk)
    disable iff (sys_rst) !sck_oe |-> !sck_out)
    else $error("sck driven high in slave mode");
  AST_HALF: assert property (@(posedge clk)
    disable iff (sys_rst)
    (sck_oe && seen_r && tog) |-> cnt_r == half - 12'h001)
    else $error("master sck half period wrong");
  AST_AUX_PIN: assert property (@(posedge clk)
    disable iff (sys_rst)
    !aux_r |-> (sout_out == port_out && sout_oe == port_oe))
    else $error("serial out pin not plain port");
  AST_AUX_DRV: assert property (@(posedge clk)
    disable iff (sys_rst) aux_r |-> sout_oe)
    else $error("serial out not driven");
  AST_IRQ_OR: assert property (@(posedge clk)
    disable iff (sys_rst) port_irq |-> irq_vec2)
    else $error("port request lost");
  AST_IRQ_MASK: assert property (@(posedge clk)
    disable iff (sys_rst) (!ie_r && !port_irq) |-> !irq_vec2)
    else $error("masked request seen");
  AST_RST: assert property (@(posedge clk)
    sys_rst |=> (!sck_oe && !sck_out && prdata == 32'h0))
    else $error("outputs not cleared by reset");
  AST_SLVERR: assert property (@(posedge clk)
    disable iff (sys_rst) pslverr == (psel && penable && !map_ok))
    else $error("slave error wrong");
endmodule : ssp_port_sva

bind ssp_port ssp_port_sva u_sva (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out),
  .sck_oe(sck_oe), .sin(sin), .sout_out(sout_out), .sout_oe(sout_oe),
  .port_out(port_out), .port_oe(port_oe), .port_irq(port_irq),
  .irq_vec2(irq_vec2)
);

/* File: dv/ssp_slave_model.sv */
// Purpose: External serial slave facing the port in master mode and in slave mode
// Assumes: Mode bits given by the bench; load starts a frame; the clock
//          comes from the port, or from the bench when the port is slave
// Notes:   Shifts in a toggling pattern so stale data never repeats

`timescale 1ns/100ps

module ssp_slave_model (
  // Serial pins
  input  wire logic       sck,
  input  wire logic       sout,
  output logic            sin,
  // Mode and data
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  logic [7:0] sr_r = 8'h00;
  logic       first_r = 1'b0;

  // Slave drives the device input pin
  assign sin = sr_r[7];

  // Fresh frame
  always @(posedge load) begin
    sr_r = tx_byte;
    rx_byte = 8'h00;
    first_r = 1'b1;
  end

  // Capture on the sampling edge, change on the other
  always @(sck) begin
    if ((sck != pol) ^ pha) rx_byte = {rx_byte[6:0], sout};
    else if (pha && first_r) first_r = 1'b0;
    else sr_r = {sr_r[6:0], ~sr_r[0]};
  end
endmodule : ssp_slave_model

/* File: dv/ssp_port_test.sv */
// Purpose: Self-checking bench for the serial shift port
// Assumes: Port as master, then as slave with the bench giving SCK
// Notes:   Reads queue their expectation; a monitor compares

`timescale 1ns/100ps

module ssp_port_test;
  import ssp_pkg::*;

  localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] A_DIV  = {IDX_DIV, 2'b00};
  localparam logic [9:0] A_DATA = {IDX_DATA, 2'b00};
  localparam logic [9:0] A_AUX  = {IDX_AUX, 2'b00};
  localparam logic [9:0] A_BAD  = 10'h000;

  logic        clk = 1'b0, sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic        port_out = 1'b0, port_oe = 1'b0, port_irq = 1'b0;
  logic        pol_v = 1'b0, pha_v = 1'b0, p_ld = 1'b0;
  logic        ext_sck = 1'b0;
  logic [7:0]  p_tx = '0;
  wire  [31:0] prdata;
  wire  [7:0]  p_rx;
  wire         pready, pslverr, sck_out, sck_oe, sin;
  wire         sout_out, sout_oe, irq_vec2;
  wire         sck_w = sck_oe ? sck_out : ext_sck;
  logic [33:0] exp_q[$];
  logic [33:0] q_e;
  int          n_errors = 0;
  int          comparisons = 0;

  ssp_port uut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .sin(sin), .sout_out(sout_out),
    .sout_oe(sout_oe), .port_out(port_out), .port_oe(port_oe),
    .port_irq(port_irq), .irq_vec2(irq_vec2)
  );

  ssp_slave_model u_slave (
    .sck(sck_w), .sout(sout_out), .sin(sin), .pol(pol_v), .pha(pha_v),
    .load(p_ld), .tx_byte(p_tx), .rx_byte(p_rx)
  );

  always #25 clk = ~clk;

  // Plain port drive of the shared pin
  always @(posedge clk) begin
    port_out <= 1'($urandom % 2);
    port_oe <= 1'($urandom % 2);
  end

  task end_of_test();
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer, held until pready
  task apb(input logic w, input logic [9:0] a, input logic [7:0] wd,
           output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] t;
    apb(1'b1, a, d, t);
  endtask : wr

  task rdc(input logic [9:0] a, input logic [32:0] e);
    logic [31:0] t;
    exp_q.push_back({1'b1, e});
    apb(1'b0, a, 8'h00, t);
  endtask : rdc

  // Poll the active bit until it clears
  task idle();
    logic [31:0] t;
    for (int k = 0; k < 3000; k++) begin
      exp_q.push_back(34'h0);
      apb(1'b0, A_CTRL, 8'h00, t);
      if (t[B_ACTIVE] === 1'b0) break;
    end
  endtask : idle

  task pload(input logic [7:0] v);
    p_tx <= v;
    p_ld <= 1'b1;
    @(posedge clk);
    p_ld <= 1'b0;
  endtask : pload

  // Mode, divider, data, slave, then start
  task setup(input logic [7:0] c, dv, dd, ss);
    wr(A_CTRL, c);
    wr(A_DIV, dv);
    wr(A_DATA, dd);
    pload(ss);
    wr(A_CTRL, c | 8'h80);
  endtask : setup

  // Read results as they appear
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite
        && exp_q.size() > 0) begin
      q_e = exp_q.pop_front();
      if (q_e[33]) chk("apb read", q_e[32:0], {pslverr, prdata});
    end
  end

  initial begin
    #3000000;
    n_errors++;
    end_of_test();
  end

  initial begin
    logic [7:0] c, dv, d, s, e;
    logic [3:0] ln;
    logic       ie;
    d = 8'($urandom(64088));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(A_CTRL, 33'h0);
    rdc(A_DIV, 33'h0);
    rdc(A_BAD, 33'h100000000);
    wr(A_CTRL, 8'h73);
    rdc(A_CTRL, 33'h73);
    wr(A_AUX, 8'h01);
    // Four master modes, then slave mode clocked by the bench
    for (int m = 0; m < 5; m++) begin
      pol_v <= m[0];
      pha_v <= m[1];
      ie = (m != 1);
      ln = (m == 3) ? 4'h4 : 4'h8;
      c = {1'b0, ie, m[1], m != 4, 1'b1, 1'b0, m == 2, m[0]};
      dv = {1'b0, ln, 3'(m % 3)};
      d = 8'($urandom);
      s = 8'($urandom);
      setup(c, dv, d, s);
      if (m == 4) begin
        repeat (16) begin
          repeat (8) @(posedge clk);
          ext_sck <= ~ext_sck;
        end
      end
      idle();
      e = (ln == 4'h8) ? s : {d[3:0], s[7:4]};
      rdc(A_DATA, {25'h0, e});
      rdc(A_DIV, {25'h0, ie, dv[6:0]});
      rdc(A_CTRL, {25'h0, c});
      chk("irq", {32'h0, ie}, {32'h0, irq_vec2});
      e = (ln == 4'h8) ? d : {4'h0, d[7:4]};
      chk("slave rx", {25'h0, e}, {25'h0, p_rx});
      wr(A_DIV, dv);
      chk("irq clr", 33'h0, {32'h0, irq_vec2});
    end
    pol_v <= 1'b0;
    pha_v <= 1'b0;
    setup(8'h14, 8'h40, d, 8'h00);
    repeat (300) @(posedge clk);
    wr(A_DATA, ~d);
    rdc(A_CTRL, 33'h94);
    pload(8'h80);
    idle();
    rdc(A_DATA, 33'h0);
    chk("gated rx", {25'h0, d}, {25'h0, p_rx});
    setup(8'h58, 8'h41, d, s);
    repeat (100) @(posedge clk);
    wr(A_DIV, 8'h00);
    wr(A_CTRL, 8'h58);
    rdc(A_DIV, 33'hc1);
    rdc(A_CTRL, 33'h58);
    chk("abort irq", 33'h1, {32'h0, irq_vec2});
    wr(A_DIV, 8'h01);
    port_irq <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk("port irq", 33'h1, {32'h0, irq_vec2});
    port_irq <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk("irq idle", 33'h0, {32'h0, irq_vec2});
    end_of_test();
  end
endmodule : ssp_port_test
